// File: hdl/pin_mux_defs.svh
// Constants for the pin function multiplexer: offsets, fields, resets.
// Notes on behaviour
// (R1) Register indices zero to twelve are reserved, read as zero and ignore writes.
// (R2) Each low pin has a 2-bit field where 00 selects fiber signal detect and 11 hands it to GPIO.
// (R3) Each two-wire clock pin field in bits 15:8 selects the serial clock with 00 and GPIO with 11.
// (R4) GPIO selection for clock pin n only takes effect while two-wire mux control bit n is clear.
// (R5) Bits 15:14 of the second control register put both upper pins under GPIO control with 11.
// (R6) Bit 13 is an active-low output enable for the low power hold pin, default input.
// (R7) While the hold pin is an output it is driven with bit 12, default zero.
// (R8) Read-only bit 11 returns the current level of the hold pin.
// (R9) With bit 10 set two-wire outputs are released instead of driven high, else both levels are driven.
// (R10) With bit 9 set LED outputs are released instead of driven high, else both levels are driven.
// (R11) Bits 3:2 select the quick link loss output with 00 and GPIO with 11.
// (R12) Bits 1:0 select two-wire data with 00 and GPIO with 11, bits 5:4 and 7:6 give GPIO with 11.
// (R13) The pin input register returns the fourteen pin levels in bits 13:0, bits 15:14 zero.
// (R14) Software selects the general purpose page before access and returns to the main page after.
// (R15) A pin under GPIO control is driven only when its output enable bit is set.
// (R16) Pin levels pass a synchroniser before they can be read.
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define PM_NPINS          14
`define PM_NSYNC          15
`define PM_HOLD_SYNC_BIT  14

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define PM_IDX_RSVD_LAST  6'h0C
`define PM_IDX_FUNC_SEL   6'h0D
`define PM_IDX_CTL_TWO    6'h0E
`define PM_IDX_PIN_IN     6'h0F
`define PM_IDX_GPIO_DATA  6'h10
`define PM_IDX_GPIO_DIR   6'h11

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define PM_RST_FUNC_SEL   16'h0000
`define PM_RST_CTL_TWO    16'h2600
`define PM_RST_GPIO       14'h0000
`define PM_CTL_TWO_WMASK  16'hF6FF

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define PM_BIT_HOLD_OE_N  13
`define PM_BIT_HOLD_DATA  12
`define PM_BIT_HOLD_IN    11
`define PM_BIT_TWI_HIZ    10
`define PM_BIT_LED_HIZ    9
`define PM_CODE_DEDICATED 2'b00
`define PM_CODE_GPIO      2'b11
`define PM_PIN_SCL_FIRST  4
`define PM_PIN_SDA        8
`define PM_PIN_LINK_LOSS  9
`define PM_PIN_PAIR_FIRST 12

`endif

// File: hdl/pin_mux_pkg.sv
// Types shared by the pin function multiplexer modules.
package pin_mux_pkg;
`include "pin_mux_defs.svh"

  // State of the register and pin driver top.
  typedef struct packed {
    logic [15:0]             func_sel;
    logic [15:0]             ctl_two;
    logic [`PM_NPINS-1:0]    gpio_data;
    logic [`PM_NPINS-1:0]    gpio_dir;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    slverr;
    logic [`PM_NPINS-1:0]    pin_out;
    logic [`PM_NPINS-1:0]    pin_oe;
    logic                    hold_out;
    logic                    hold_oe;
    logic [3:0]              sig_det;
    logic                    sda_level;
    logic                    led_rel;
    logic                    twi_rel;
  } top_state_t;

  // State of the pin input synchroniser.
  typedef struct packed {
    logic [`PM_NSYNC-1:0] s1;
    logic [`PM_NSYNC-1:0] s2;
    logic [`PM_NSYNC-1:0] s3;
    logic [`PM_NSYNC-1:0] level;
  } sync_state_t;

endpackage : pin_mux_pkg

// File: hdl/pin_sync_if.sv
// Interface between the top and the pin input synchroniser.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  import pin_mux_pkg::*;
  logic [`PM_NSYNC-1:0] raw;
  logic [`PM_NSYNC-1:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface : pin_sync_if
`default_nettype wire

// File: hdl/pin_input_sync.sv
// Three-stage synchroniser with agreement filter for the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_input_sync
  import pin_mux_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Pin levels in and filtered levels out.
  pin_sync_if.sync  pins
);

  sync_state_t state_reg;
  sync_state_t state_next;
  logic [`PM_NSYNC-1:0] agree;

  // A level is taken only when stages two and three agree; stage one
  // feeds stage two alone so metastability never reaches the filter.
  always_comb begin
    state_next = state_reg;
    agree = ~(state_reg.s2 ^ state_reg.s3);
    state_next.s1 = pins.raw;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.level = (agree & state_reg.s3) | (~agree & state_reg.level); // R16
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign pins.level = state_reg.level;

endmodule : pin_input_sync
`default_nettype wire

// File: hdl/pin_drive_mux.sv
// Per-pin choice between dedicated function and GPIO drive.
`timescale 1ns/1ps
`default_nettype none
module pin_drive_mux
  import pin_mux_pkg::*;
(
  // Configuration.
  input  wire logic [15:0]          func_sel,
  input  wire logic [15:0]          ctl_two,
  input  wire logic [3:0]           twi_mux_enable,
  input  wire logic [`PM_NPINS-1:0] gpio_data,
  input  wire logic [`PM_NPINS-1:0] gpio_dir,
  // Dedicated function drive levels.
  input  wire logic [3:0]           twi_scl_drive,
  input  wire logic                 twi_sda_drive,
  input  wire logic                 quick_link_loss_level,
  // Pin drive.
  output var  logic [`PM_NPINS-1:0] pin_out,
  output var  logic [`PM_NPINS-1:0] pin_oe
);

  logic twi_hiz;
  assign twi_hiz = ctl_two[`PM_BIT_TWI_HIZ];

  // Each pin finds its field, decides GPIO or dedicated, then drives.
  for (genvar i = 0; i < `PM_NPINS; i++) begin : g_pin
    logic [1:0] code;
    logic       gsel;
    logic       ded_out;
    logic       ded_oe;
    if (i < `PM_PIN_SDA) begin : g_code_lo
      assign code = func_sel[2*i +: 2]; // R2 R3
    end else if (i < `PM_PIN_PAIR_FIRST) begin : g_code_mid
      assign code = ctl_two[2*(i-`PM_PIN_SDA) +: 2]; // R11 R12
    end else begin : g_code_hi
      assign code = ctl_two[15:14]; // R5
    end
    if (i >= `PM_PIN_SCL_FIRST && i < `PM_PIN_SDA) begin : g_scl
      // Mux control keeps the pin as a serial clock whatever the field.
      assign gsel = (code == `PM_CODE_GPIO) &&
                    !twi_mux_enable[i-`PM_PIN_SCL_FIRST]; // R4
      assign ded_out = twi_scl_drive[i-`PM_PIN_SCL_FIRST];
      assign ded_oe  = !(twi_hiz && ded_out); // R9
    end else if (i == `PM_PIN_SDA) begin : g_sda
      assign gsel    = (code == `PM_CODE_GPIO);
      assign ded_out = twi_sda_drive;
      assign ded_oe  = (code == `PM_CODE_DEDICATED) &&
                       !(twi_hiz && twi_sda_drive); // R9 R12
    end else if (i == `PM_PIN_LINK_LOSS) begin : g_link
      assign gsel    = (code == `PM_CODE_GPIO);
      assign ded_out = quick_link_loss_level;
      assign ded_oe  = (code == `PM_CODE_DEDICATED); // R11
    end else begin : g_plain
      // Signal detect pins are inputs; pins without a function float.
      assign gsel    = (code == `PM_CODE_GPIO);
      assign ded_out = 1'b0;
      assign ded_oe  = 1'b0;
    end
    assign pin_out[i] = gsel ? gpio_data[i] : ded_out;
    assign pin_oe[i]  = gsel ? gpio_dir[i] : ded_oe; // R15
  end

endmodule : pin_drive_mux
`default_nettype wire

// File: hdl/pin_function_mux.sv
// Top of the pin function multiplexer with its APB register file.
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux
  import pin_mux_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // APB slave.
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // GPIO pins, input, output and output enable.
  input  wire logic [`PM_NPINS-1:0] gpio_pin_in,
  output logic      [`PM_NPINS-1:0] gpio_pin_out,
  output logic      [`PM_NPINS-1:0] gpio_pin_oe,
  // Low power hold pin.
  input  wire logic                 low_power_hold_pin_in,
  output logic                      low_power_hold_pin_out,
  output logic                      low_power_hold_pin_oe,
  // Dedicated functions inside the device.
  input  wire logic [3:0]           twi_mux_enable,
  input  wire logic [3:0]           twi_scl_drive,
  input  wire logic                 twi_sda_drive,
  input  wire logic                 quick_link_loss_output,
  output logic                      twi_sda_level,
  output logic      [3:0]           fiber_signal_detect,
  output logic                      twi_release_high,
  output logic                      led_release_high
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  top_state_t state_reg;
  top_state_t state_next;
  pin_sync_if sif ();
  logic [`PM_NPINS-1:0] mux_out;
  logic [`PM_NPINS-1:0] mux_oe;
  logic [5:0]           idx;
  logic                 setup_phase;
  logic                 access_phase;
  logic                 mapped;
  logic [15:0]          ctl_two_view;
  logic [15:0]          pin_in_view;

  // ----------------------------------------------------------------------
  // Synchroniser and pin driver
  // ----------------------------------------------------------------------

  // The hold pin rides in the top bit of the synchroniser.
  assign sif.raw = {low_power_hold_pin_in, gpio_pin_in};

  pin_input_sync u_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pins   (sif.sync)
  );

  pin_drive_mux u_mux (
    .func_sel              (state_reg.func_sel),
    .ctl_two               (state_reg.ctl_two),
    .twi_mux_enable        (twi_mux_enable),
    .gpio_data             (state_reg.gpio_data),
    .gpio_dir              (state_reg.gpio_dir),
    .twi_scl_drive         (twi_scl_drive),
    .twi_sda_drive         (twi_sda_drive),
    .quick_link_loss_level (quick_link_loss_output),
    .pin_out               (mux_out),
    .pin_oe                (mux_oe)
  );

  // ----------------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------------

  // Control two reads back its stored bits plus the live hold pin level;
  // bit 8 is reserved and reads zero.
  always_comb begin
    ctl_two_view = state_reg.ctl_two & `PM_CTL_TWO_WMASK;
    ctl_two_view[`PM_BIT_HOLD_IN] = sif.level[`PM_HOLD_SYNC_BIT]; // R8
  end

  // Pin levels come from the synchroniser, so a read lags the pin by
  // about four clocks; the top two bits read zero.
  assign pin_in_view = {2'b00, sif.level[`PM_NPINS-1:0]}; // R13 R16

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign idx          = paddr[7:2];
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable && state_reg.ready;

  // Reserved indices answer without error; anything past the GPIO
  // direction register is refused with pslverr.
  assign mapped = (idx <= `PM_IDX_GPIO_DIR);

  // Byte lane merge for the 16-bit registers.
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] tmp;
    tmp = 16'h0000;
    state_next = state_reg;
    state_next.ready  = 1'b0;
    state_next.slverr = 1'b0;

    // Setup phase: answer is prepared so pready rises in the access
    // phase with zero wait states.
    if (setup_phase) begin
      state_next.ready  = 1'b1;
      state_next.slverr = !mapped;
      state_next.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (idx <= `PM_IDX_RSVD_LAST) begin
          state_next.rdata = 32'h0000_0000; // R1
        end else if (idx == `PM_IDX_FUNC_SEL) begin
          state_next.rdata = {16'h0000, state_reg.func_sel};
        end else if (idx == `PM_IDX_CTL_TWO) begin
          state_next.rdata = {16'h0000, ctl_two_view};
        end else if (idx == `PM_IDX_PIN_IN) begin
          state_next.rdata = {16'h0000, pin_in_view}; // R13
        end else if (idx == `PM_IDX_GPIO_DATA) begin
          state_next.rdata = {18'h0_0000, state_reg.gpio_data};
        end else if (idx == `PM_IDX_GPIO_DIR) begin
          state_next.rdata = {18'h0_0000, state_reg.gpio_dir};
        end else begin
          state_next.rdata = 32'h0000_0000;
        end
      end
    end

    // Access phase: writes land at the edge that completes the transfer.
    // Reserved and read-only registers drop the write.
    if (access_phase && pwrite) begin
      if (idx == `PM_IDX_FUNC_SEL) begin
        state_next.func_sel = merge16(state_reg.func_sel, pwdata, pstrb); // R2 R3
      end else if (idx == `PM_IDX_CTL_TWO) begin
        tmp = merge16(state_reg.ctl_two, pwdata, pstrb);
        state_next.ctl_two = tmp & `PM_CTL_TWO_WMASK; // R5 R6 R7 R9 R10
      end else if (idx == `PM_IDX_GPIO_DATA) begin
        tmp = merge16({2'b00, state_reg.gpio_data}, pwdata, pstrb);
        state_next.gpio_data = tmp[`PM_NPINS-1:0];
      end else if (idx == `PM_IDX_GPIO_DIR) begin
        tmp = merge16({2'b00, state_reg.gpio_dir}, pwdata, pstrb);
        state_next.gpio_dir = tmp[`PM_NPINS-1:0]; // R15
      end
    end

    // Pin drive is registered so the pins never glitch on mux decode.
    state_next.pin_out  = mux_out;
    state_next.pin_oe   = mux_oe; // R15
    state_next.hold_oe  = !state_reg.ctl_two[`PM_BIT_HOLD_OE_N]; // R6
    state_next.hold_out = state_reg.ctl_two[`PM_BIT_HOLD_DATA]; // R7

    // Signal detect is passed on only while its pin is not a GPIO.
    for (int i = 0; i < 4; i++) begin
      state_next.sig_det[i] =
        (state_reg.func_sel[2*i +: 2] != `PM_CODE_GPIO) &&
        sif.level[i]; // R2
    end
    state_next.sda_level = sif.level[`PM_PIN_SDA]; // R12
    state_next.twi_rel   = state_reg.ctl_two[`PM_BIT_TWI_HIZ]; // R9
    state_next.led_rel   = state_reg.ctl_two[`PM_BIT_LED_HIZ]; // R10
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset leaves every pin released and every field at its default.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.func_sel  <= `PM_RST_FUNC_SEL;
      state_reg.ctl_two   <= `PM_RST_CTL_TWO;
      state_reg.gpio_data <= `PM_RST_GPIO;
      state_reg.gpio_dir  <= `PM_RST_GPIO;
      state_reg.twi_rel   <= 1'b1;
      state_reg.led_rel   <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata                 = state_reg.rdata;
  assign pready                 = state_reg.ready;
  assign pslverr                = state_reg.slverr;
  assign gpio_pin_out           = state_reg.pin_out;
  assign gpio_pin_oe            = state_reg.pin_oe;
  assign low_power_hold_pin_out = state_reg.hold_out;
  assign low_power_hold_pin_oe  = state_reg.hold_oe;
  assign twi_sda_level          = state_reg.sda_level;
  assign fiber_signal_detect    = state_reg.sig_det;
  assign twi_release_high       = state_reg.twi_rel;
  assign led_release_high       = state_reg.led_rel;

endmodule : pin_function_mux
`default_nettype wire

// File: dv/pin_far_side.sv
// Model of the pins, modules and two-wire devices outside the block.
`timescale 1ns/1ps
`default_nettype none
module pin_far_side
  import pin_mux_pkg::*;
(
  // Clock.
  input  wire logic                 clock,
  // Device drive.
  input  wire logic [`PM_NPINS-1:0] pin_out,
  input  wire logic [`PM_NPINS-1:0] pin_oe,
  input  wire logic                 hold_out,
  input  wire logic                 hold_oe,
  // Outside drive, set by the bench.
  input  wire logic [`PM_NPINS-1:0] ext_level,
  input  wire logic [`PM_NPINS-1:0] ext_drive,
  input  wire logic                 hold_ext,
  // Resolved pin levels.
  output logic      [`PM_NPINS-1:0] pin_wire,
  output logic                      hold_wire
);
  // Pins 4 to 8 carry the two-wire bus and have external pull-ups.
  localparam logic [`PM_NPINS-1:0] PULL_UP = 14'h01F0;
  logic [`PM_NPINS-1:0] float_q = 14'h0000;

  // A floating line wanders, so a stale level can never pass for a read.
  always @(posedge clock) begin
    float_q <= ~float_q;
  end

  // The device wins where it drives; released lines take the outside drive, else fall to pull or drift.
  assign pin_wire = (pin_oe & pin_out)
                  | (~pin_oe & ext_drive & ext_level)
                  | (~pin_oe & ~ext_drive & (PULL_UP | float_q));
  assign hold_wire = hold_oe ? hold_out : hold_ext;
endmodule : pin_far_side
`default_nettype wire

// File: dv/pin_function_mux_monitor.sv
// Port checker for the pin function multiplexer top.
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux_monitor (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // APB.
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin controls.
  input wire logic        low_power_hold_pin_out,
  input wire logic        low_power_hold_pin_oe,
  input wire logic        twi_release_high,
  input wire logic        led_release_high
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // A setup cycle, and a write to the second control register.
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence ctl_wr_s;
    psel && penable && pready && pwrite && clk_en && pstrb[1]
      && paddr[7:2] == 6'h0E;
  endsequence

  // Control bits reach the pins one edge after the register lands.
  a_pready_follows: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (pready && clk_en |=> !pready)
    else $error("pready held too long");
  a_error_range: assert property
    (pready |-> pslverr == (paddr[7:2] > 6'h11))
    else $error("pslverr does not match address range");
  a_rsvd_zero: assert property (pready && !pwrite && paddr[7:2] <= 6'h0C
    |-> prdata == 32'h0000_0000) else $error("reserved read not zero");
  a_input_top: assert property (pready && !pwrite && paddr[7:2] == 6'h0F
    |-> prdata[31:14] == 18'h0_0000) else $error("pin input top bits set");
  a_hold_dir: assert property (ctl_wr_s |-> ##2
    low_power_hold_pin_oe == !$past(pwdata[13], 2))
    else $error("hold pin direction wrong");
  a_hold_data: assert property (ctl_wr_s |-> ##2
    low_power_hold_pin_out == $past(pwdata[12], 2))
    else $error("hold pin data wrong");
  a_twi_release: assert property (ctl_wr_s |-> ##2
    twi_release_high == $past(pwdata[10], 2))
    else $error("two-wire release wrong");
  a_led_release: assert property (ctl_wr_s |-> ##2
    led_release_high == $past(pwdata[9], 2))
    else $error("led release wrong");
  a_reset_vals: assert property ($rose(rst_n) |-> twi_release_high
    && led_release_high && !low_power_hold_pin_oe && !pready)
    else $error("reset values wrong");
endmodule : pin_function_mux_monitor

bind pin_function_mux pin_function_mux_monitor mon (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_power_hold_pin_out(low_power_hold_pin_out),
  .low_power_hold_pin_oe(low_power_hold_pin_oe),
  .twi_release_high(twi_release_high), .led_release_high(led_release_high));
`default_nettype wire

// File: dv/gpio_fiber_signal_detect_pin_function_mux_test.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module gpio_fiber_signal_detect_pin_function_mux_test;
  import pin_mux_pkg::*;
  logic        clock, rst_n = 1'b0, clk_en = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, pready, pslverr;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'hF, twi_mux_enable = 4'h0, twi_scl_drive = 4'hF;
  logic [3:0]  fiber_signal_detect;
  logic [13:0] pin_in, pin_out, pin_oe, ext_level = 14'h0000;
  logic [13:0] ext_drive = 14'h3FFF;
  logic        hold_in, hold_out, hold_oe, hold_ext = 1'b0, sda_drive = 1'b1;
  logic        link_loss = 1'b0, sda_level, twi_rel, led_rel;
  int          err_count = 0, tests_run = 0, cycles = 0;

  pin_function_mux dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_pin_in(pin_in), .gpio_pin_out(pin_out),
    .gpio_pin_oe(pin_oe), .low_power_hold_pin_in(hold_in),
    .low_power_hold_pin_out(hold_out), .low_power_hold_pin_oe(hold_oe),
    .twi_mux_enable(twi_mux_enable), .twi_scl_drive(twi_scl_drive),
    .twi_sda_drive(sda_drive), .quick_link_loss_output(link_loss),
    .twi_sda_level(sda_level), .fiber_signal_detect(fiber_signal_detect),
    .twi_release_high(twi_rel), .led_release_high(led_rel));
  pin_far_side far (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .hold_out(hold_out), .hold_oe(hold_oe), .ext_level(ext_level),
    .ext_drive(ext_drive), .hold_ext(hold_ext), .pin_wire(pin_in),
    .hold_wire(hold_in));

  // Clock at 250 MHz.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb_xfer(input logic wr, input logic [5:0] idx,
                          input logic [15:0] wd);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    check("pready", 32'd1, n);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic rd_chk(input string name, input logic [5:0] idx,
                        input logic [31:0] exp, input logic exp_err);
    apb_xfer(1'b0, idx, 16'h0000);
    check(name, exp, rd);
    check("pslverr", exp_err, err);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc

  // The run should take a couple of hundred cycles; a hang counts as a mismatch.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    wait_cyc(20);
    rst_n <= 1'b1;
    wait_cyc(6);
    for (int i = 0; i < 13; i++)
      rd_chk("rsvd", 6'(i), 32'h0000_0000, 1'b0);
    apb_xfer(1'b1, 6'h05, 16'hFFFF);
    rd_chk("rsvd_wr", 6'h05, 32'h0000_0000, 1'b0);
    rd_chk("func_sel", 6'h0D, 32'h0000_0000, 1'b0);
    rd_chk("ctl_two", 6'h0E, 32'h0000_2600, 1'b0);
    rd_chk("unmapped", 6'h12, 32'h0000_0000, 1'b1);
    // Low pins: detect by default, GPIO only with code 11.
    ext_level <= 14'h000A;
    apb_xfer(1'b1, 6'h10, 16'h2AA1);
    apb_xfer(1'b1, 6'h11, 16'h3FF5);
    wait_cyc(6);
    check("fiber", 4'hA, fiber_signal_detect);
    for (int c = 1; c < 4; c++) begin
      apb_xfer(1'b1, 6'h0D, {8'h00, {4{2'(c)}}});
      wait_cyc(3);
      check("oe_low", (c == 3) ? 4'h5 : 4'h0, pin_oe[3:0]);
      check("fiber_c", (c == 3) ? 4'h0 : 4'hA, fiber_signal_detect);
      check("out_low", (c == 3) ? 4'h1 : 4'h0, pin_out[3:0]);
    end
    // Clock pins: mux enable keeps the serial clock.
    twi_mux_enable <= 4'b0101;
    apb_xfer(1'b1, 6'h0D, 16'hFF00);
    wait_cyc(3);
    check("scl_oe", 4'b1010, pin_oe[7:4]);
    check("scl_out", 4'b1010, pin_out[7:4] & 4'b1010);
    twi_mux_enable <= 4'b0000;
    wait_cyc(3);
    check("scl_gpio", 8'hFA, {pin_oe[7:4], pin_out[7:4]});
    twi_scl_drive <= 4'b0011;
    apb_xfer(1'b1, 6'h0D, 16'h0000);
    apb_xfer(1'b1, 6'h0E, 16'h2200);
    wait_cyc(3);
    check("scl_push", 8'hF3, {pin_oe[7:4], pin_out[7:4]});
    check("rel", 2'b01, {twi_rel, led_rel});
    // Upper pins under GPIO, hold pin as output.
    apb_xfer(1'b1, 6'h0E, 16'hD0FF);
    wait_cyc(8);
    check("hold", 4'b1100, {hold_oe, hold_out, twi_rel, led_rel});
    check("up_oe", 6'h3F, pin_oe[13:8]);
    check("up_out", 6'h2A, pin_out[13:8]);
    rd_chk("ctl_rb", 6'h0E, 32'h0000_D8FF, 1'b0);
    // Dedicated data and link loss pins, then reserved codes release pins 8 to 11.
    link_loss <= 1'b1;
    sda_drive <= 1'b0;
    twi_scl_drive <= 4'hF;
    apb_xfer(1'b1, 6'h0E, 16'h2600);
    wait_cyc(3);
    check("ded_oe", 6'h03, pin_oe[13:8]);
    check("ded_out", 2'b10, pin_out[9:8]);
    apb_xfer(1'b1, 6'h0E, 16'h2655);
    ext_level <= 14'h2B5C;
    hold_ext  <= 1'b1;
    apb_xfer(1'b1, 6'h0F, 16'hFFFF);
    wait_cyc(8);
    check("rsvd_oe", 14'h0000, pin_oe);
    rd_chk("pin_in", 6'h0F, 32'h0000_2B5C, 1'b0);
    check("sda_lvl", 1'b1, sda_level);
    check("fiber_lv", 4'hC, fiber_signal_detect);
    rd_chk("hold_in", 6'h0E, 32'h0000_2E55, 1'b0);
    // A frozen clock enable holds every flop.
    clk_en    <= 1'b0;
    ext_level <= 14'h0003;
    wait_cyc(8);
    check("freeze", 4'hC, fiber_signal_detect);
    clk_en <= 1'b1;
    wait_cyc(8);
    check("thaw", 4'h3, fiber_signal_detect);
    // A second reset in mid-run restores the defaults.
    rst_n <= 1'b0;
    wait_cyc(3);
    rst_n <= 1'b1;
    wait_cyc(6);
    rd_chk("ctl_rst", 6'h0E, 32'h0000_2E00, 1'b0);
    rd_chk("gpio_rst", 6'h11, 32'h0000_0000, 1'b0);
    test_done();
  end
endmodule : gpio_fiber_signal_detect_pin_function_mux_test
`default_nettype wire
